//--- include/emb_cfg.svh
// Constants for the external memory bus interface
`ifndef EMB_CFG_SVH
`define EMB_CFG_SVH
`define EMB_ON_CHIP_TOP 16'h1FFF
`define EMB_RST_CYCLES 4'h2
`define EMB_MC_CLKS 4'hC
`define EMB_PH_ALE_FALL 4'h2
`define EMB_PH_DATA 4'h4
`define EMB_PH_STROBE_ON 4'h5
`define EMB_PH_STROBE_OFF 4'hA
`define EMB_PH_END 4'hB
`define EMB_ALLONES8 8'hFF
`define EMB_ZERO8 8'h00
`endif

//--- include/emb_pkg.sv
// Types for the external memory bus interface
package emb_pkg;
    typedef enum logic [3:0] {
        EMB_IDLE = 4'b0001,
        EMB_ADDR = 4'b0010,
        EMB_DATA = 4'b0100,
        EMB_DONE = 4'b1000
    } emb_state_t;
    typedef enum logic [1:0] {
        EMB_ACC_CODE = 2'h0,
        EMB_ACC_READ = 2'h1,
        EMB_ACC_WRITE = 2'h2
    } emb_acc_t;
endpackage : emb_pkg

//--- verilog/emb_reset_sync.sv
// Reset release and reset pin qualification
`include "emb_cfg.svh"
module emb_reset_sync (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic reset_pin_in,
    output logic rstn_out
);
    import emb_pkg::*;
    typedef struct packed {
        logic [1:0] rel;
        logic [1:0] pin_sync;
        logic [3:0] clk_cnt;
        logic [3:0] mc_cnt;
        logic hold;
    } emb_rs_t;
    emb_rs_t s_reg, s_next;
    // ========================================
    // Two machine cycles of high reset pin
    always_comb begin
        s_next = s_reg;
        s_next.rel = {s_reg.rel[0], 1'b1};
        s_next.pin_sync = {s_reg.pin_sync[0], reset_pin_in};
        s_next.hold = 1'b0;
        if (s_reg.pin_sync[1]) begin
            if (s_reg.clk_cnt == `EMB_MC_CLKS - 4'h1) begin
                s_next.clk_cnt = 4'h0;
                if (s_reg.mc_cnt != `EMB_RST_CYCLES) begin
                    s_next.mc_cnt = s_reg.mc_cnt + 4'h1;
                end
            end else begin
                s_next.clk_cnt = s_reg.clk_cnt + 4'h1;
            end
            s_next.hold = (s_reg.mc_cnt == `EMB_RST_CYCLES); // R10
        end else begin
            s_next.clk_cnt = 4'h0;
            s_next.mc_cnt = 4'h0;
        end
    end
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
    assign rstn_out = s_reg.rel[1] & ~s_reg.hold;
endmodule : emb_reset_sync

//--- verilog/emb_bus_if.sv
// External memory bus interface top
// ========================================
// Summary of operation
// R1: A low external access select sends every program fetch to the external bus.
// R2: With access select high and an on-chip address, no fetch address or code appears on the bus.
// R3: Each external fetch or code table read asserts the program fetch strobe.
// R4: Internal program accesses give no program fetch strobe pulse at all.
// R5: The latch strobe pulses so an outside latch captures the low address byte, which it then holds.
// R6: The low port carries the low address first and the data byte after.
// R7: The high address port carries the upper address byte during external accesses.
// R8: External data writes produce the active low write strobe.
// R9: External data reads produce the active low read strobe, separate from the fetch strobe.
// R10: A reset pin high for two machine cycles resets the block; the outside holds it that long.
// R11: Program and data spaces are separate 64K spaces chosen by strobe, addressed by 16 bits.
// R12: With the latch strobe off bit set, the latch strobe only toggles during external accesses.
// R13: Fetch, read and write strobes are active low and the latch strobe falls before data phase.
`include "emb_cfg.svh"
module emb_bus_if (
    input wire logic mclk_in,
    input wire logic rstn_in,
    input wire logic reset_pin_in,
    input wire logic external_access_select_n_in,
    input wire logic latch_strobe_off_bit_in,
    input wire logic req_valid_in,
    input wire emb_pkg::emb_acc_t req_kind_in,
    input wire logic [15:0] req_addr_in,
    input wire logic [7:0] req_wdata_in,
    input wire logic [7:0] low_address_data_port_in,
    output logic req_ready_out,
    output logic rsp_valid_out,
    output logic rsp_internal_out,
    output logic [7:0] rsp_data_out,
    output logic [7:0] low_address_data_port_out,
    output logic low_address_data_port_oe_n_out,
    output logic [7:0] high_address_port_out,
    output logic address_latch_strobe_out,
    output logic program_fetch_strobe_n_out,
    output logic read_strobe_n_out,
    output logic write_strobe_n_out
);
    import emb_pkg::*;
    typedef struct packed {
        emb_state_t st;
        logic [3:0] ph;
        emb_acc_t kind;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [1:0] ea_sync;
        logic [1:0] ao_sync;
        logic [7:0] ad_out;
        logic ad_oe_n;
        logic [7:0] hi_out;
        logic ale;
        logic program_fetch_strobe_n;
        logic rd_n;
        logic wr_n;
        logic ready;
        logic rsp_valid;
        logic rsp_int;
        logic [7:0] rsp_data;
    } emb_bus_t;
    emb_bus_t s_reg, s_next;
    logic rstn_sync;
    emb_reset_sync u_rst (
        .mclk_in(mclk_in),
        .rstn_in(rstn_in),
        .reset_pin_in(reset_pin_in),
        .rstn_out(rstn_sync)
    );
    function automatic logic is_on_chip(input logic [15:0] a);
        is_on_chip = (a <= `EMB_ON_CHIP_TOP);
    endfunction : is_on_chip
    // ========================================
    // Bus cycle sequencer
    always_comb begin
        s_next = s_reg;
        s_next.ea_sync = {s_reg.ea_sync[0], external_access_select_n_in};
        s_next.ao_sync = {s_reg.ao_sync[0], latch_strobe_off_bit_in};
        s_next.rsp_valid = 1'b0;
        case (s_reg.st)
            EMB_IDLE: begin
                s_next.ready = 1'b1;
                s_next.ad_oe_n = 1'b1;
                s_next.ale = ~s_reg.ao_sync[1] & ~s_reg.ale; // R12
                if (req_valid_in && s_reg.ready) begin
                    s_next.ready = 1'b0;
                    s_next.kind = req_kind_in;
                    s_next.addr = req_addr_in;
                    s_next.wdata = req_wdata_in;
                    if (req_kind_in == EMB_ACC_CODE && s_reg.ea_sync[1]
                        && is_on_chip(req_addr_in)) begin
                        s_next.st = EMB_DONE; // R2 R4
                        s_next.rsp_int = 1'b1;
                    end else begin
                        s_next.st = EMB_ADDR; // R1 R11
                        s_next.rsp_int = 1'b0;
                        s_next.ph = 4'h0;
                        s_next.ale = 1'b1; // R5 R12
                        s_next.ad_out = req_addr_in[7:0]; // R6
                        s_next.ad_oe_n = 1'b0;
                        s_next.hi_out = req_addr_in[15:8]; // R7
                    end
                end
            end
            EMB_ADDR: begin
                s_next.ph = s_reg.ph + 4'h1;
                if (s_reg.ph == `EMB_PH_ALE_FALL) begin
                    s_next.ale = 1'b0; // R13
                end
                if (s_reg.ph == `EMB_PH_DATA) begin
                    s_next.st = EMB_DATA;
                    s_next.ad_oe_n = (s_reg.kind != EMB_ACC_WRITE); // R6
                    s_next.ad_out = (s_reg.kind == EMB_ACC_WRITE) ? s_reg.wdata : `EMB_ALLONES8;
                end
            end
            EMB_DATA: begin
                s_next.ph = s_reg.ph + 4'h1;
                if (s_reg.ph == `EMB_PH_STROBE_ON) begin
                    s_next.program_fetch_strobe_n = (s_reg.kind != EMB_ACC_CODE); // R3 R13
                    s_next.rd_n = (s_reg.kind != EMB_ACC_READ); // R9
                    s_next.wr_n = (s_reg.kind != EMB_ACC_WRITE); // R8
                end
                if (s_reg.ph == `EMB_PH_STROBE_OFF) begin
                    s_next.rsp_data = low_address_data_port_in; // R6
                    s_next.program_fetch_strobe_n = 1'b1;
                    s_next.rd_n = 1'b1;
                    s_next.wr_n = 1'b1;
                end
                if (s_reg.ph == `EMB_PH_END) begin
                    s_next.st = EMB_DONE;
                    s_next.ad_oe_n = 1'b1;
                end
            end
            EMB_DONE: begin
                s_next.rsp_valid = 1'b1;
                s_next.rsp_data = s_reg.rsp_int ? `EMB_ZERO8 : s_reg.rsp_data;
                s_next.st = EMB_IDLE;
            end
            default: begin
                s_next.st = EMB_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk_in or negedge rstn_sync) begin
        if (!rstn_sync) begin
            s_reg <= '0;
            s_reg.st <= EMB_IDLE;
            s_reg.ad_oe_n <= 1'b1;
            s_reg.program_fetch_strobe_n <= 1'b1;
            s_reg.rd_n <= 1'b1;
            s_reg.wr_n <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end
    assign req_ready_out = s_reg.ready;
    assign rsp_valid_out = s_reg.rsp_valid;
    assign rsp_internal_out = s_reg.rsp_int;
    assign rsp_data_out = s_reg.rsp_data;
    assign low_address_data_port_out = s_reg.ad_out;
    assign low_address_data_port_oe_n_out = s_reg.ad_oe_n;
    assign high_address_port_out = s_reg.hi_out;
    assign address_latch_strobe_out = s_reg.ale;
    assign program_fetch_strobe_n_out = s_reg.program_fetch_strobe_n;
    assign read_strobe_n_out = s_reg.rd_n;
    assign write_strobe_n_out = s_reg.wr_n;
    // ========================================
    // Checks
    sequence ext_start;
        s_reg.st == EMB_IDLE && s_reg.ready && req_valid_in && !(req_kind_in == EMB_ACC_CODE
            && s_reg.ea_sync[1] && is_on_chip(req_addr_in));
    endsequence
    sequence int_start;
        s_reg.st == EMB_IDLE && s_reg.ready && req_valid_in && req_kind_in == EMB_ACC_CODE
            && s_reg.ea_sync[1] && is_on_chip(req_addr_in);
    endsequence
    chk_int_no_program_fetch_strobe: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R4
        s_reg.rsp_int |-> program_fetch_strobe_n_out) else $error("fetch strobe on internal access");
    chk_ea_low_ext: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R1
        (s_reg.st == EMB_IDLE && s_reg.ready && req_valid_in && !s_reg.ea_sync[1])
        |=> s_reg.st == EMB_ADDR) else $error("external fetch not started");
    chk_int_no_bus: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R2
        (s_reg.st == EMB_DONE && s_reg.rsp_int) |-> low_address_data_port_oe_n_out)
        else $error("bus driven on internal fetch");
    chk_program_fetch_strobe_code: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R3
        ext_start ##1 (s_reg.kind == EMB_ACC_CODE) |-> ##6 !program_fetch_strobe_n_out)
        else $error("fetch strobe missing");
    chk_ale_pulse: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R5 R13
        ext_start |=> address_latch_strobe_out [*3] ##1 !address_latch_strobe_out)
        else $error("latch strobe pulse wrong");
    chk_addr_low: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R6
        ext_start |=> low_address_data_port_out == $past(req_addr_in[7:0]) && !low_address_data_port_oe_n_out)
        else $error("low address not driven");
    chk_addr_high: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R7
        ext_start |=> high_address_port_out == $past(req_addr_in[15:8])) else $error("high address wrong");
    chk_wr_strobe: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R8
        !write_strobe_n_out |-> s_reg.kind == EMB_ACC_WRITE && !address_latch_strobe_out)
        else $error("write strobe misuse");
    chk_rd_strobe: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R9 R11
        !read_strobe_n_out |-> s_reg.kind == EMB_ACC_READ && program_fetch_strobe_n_out)
        else $error("read strobe misuse");
    chk_ale_off: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R12
        (s_reg.st == EMB_IDLE && s_reg.ao_sync[1] && s_reg.ao_sync[0] && !s_reg.ale) |=>
        (!address_latch_strobe_out || s_reg.st == EMB_ADDR)) else $error("latch strobe toggles while off");
    chk_int_rsp: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R2
        int_start |-> ##2 rsp_valid_out && rsp_internal_out) else $error("internal fetch answer late");
    chk_ext_rsp: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R6
        ext_start |-> ##14 rsp_valid_out && !rsp_internal_out) else $error("external access answer late");
    chk_one_strobe: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R11
        $onehot0({~program_fetch_strobe_n_out, ~read_strobe_n_out, ~write_strobe_n_out}))
        else $error("more than one strobe active");
    chk_read_float: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R6
        (!read_strobe_n_out || !program_fetch_strobe_n_out) |-> low_address_data_port_oe_n_out)
        else $error("low port driven during read");
    chk_write_data: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R8
        !write_strobe_n_out |-> !low_address_data_port_oe_n_out && low_address_data_port_out == s_reg.wdata)
        else $error("write data not on low port");
    chk_idle_quiet: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R13
        s_reg.st == EMB_IDLE |-> program_fetch_strobe_n_out && read_strobe_n_out && write_strobe_n_out)
        else $error("strobe active while idle");
    chk_high_stable: assert property (@(posedge mclk_in) disable iff (!rstn_sync) // R7
        s_reg.st == EMB_DATA |-> $stable(high_address_port_out))
        else $error("high address moved in data phase");
endmodule : emb_bus_if

//--- bench/emb_ext_mem.sv
// External program memory, data memory and address latch model
module emb_ext_mem (
    input wire logic mclk_in,
    input wire logic [7:0] port_in,
    input wire logic [7:0] high_in,
    input wire logic ale_in,
    input wire logic program_fetch_strobe_n_in,
    input wire logic read_strobe_n_in,
    input wire logic write_strobe_n_in,
    output logic [7:0] drive_out,
    output logic [15:0] addr_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ram_reg [logic [15:0]];
    logic [7:0] low_reg = 8'h00;
    logic [7:0] idle_reg = 8'hA5;
    assign addr_out = {high_in, low_reg};
    // Latch holds the low address byte while the port carries data
    always @(negedge ale_in) low_reg <= port_in;
    always @(posedge mclk_in) idle_reg <= ~idle_reg;
    always @(posedge write_strobe_n_in) begin
        if (!$isunknown(addr_out)) ram_reg[addr_out] = port_in;
    end
    // Released port shows a changing pattern, not the last value
    always @* begin
        if (program_fetch_strobe_n_in === 1'b0) drive_out = addr_out[7:0] ^ addr_out[15:8] ^ 8'h3C;
        else if (read_strobe_n_in === 1'b0) drive_out = ram_reg.exists(addr_out) ? ram_reg[addr_out] : 8'h00;
        else drive_out = idle_reg;
    end
endmodule : emb_ext_mem

//--- bench/emb_bus_if_bench.sv
// Self-checking bench for the external memory bus interface
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module emb_bus_if_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import emb_pkg::*;
    logic mclk = 0, rstn = 0, rst_pin = 0, ea_n = 1, ao = 0, valid = 0;
    emb_acc_t kind = EMB_ACC_CODE;
    logic [15:0] addr = 16'h0000;
    logic [15:0] mem_addr;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rsp_d, p0_q, p2_q, mem_d, port_w, got_d;
    logic ready, rsp_v, rsp_int, oe_n, ale, pf_n, rd_n, wr_n, got_int;
    int error_cnt = 0, check_count = 0, n_pf, n_rd, n_wr, n_ale, n_oe;
    // ========================================
    // Structure
    assign port_w = (oe_n === 1'b0) ? p0_q : mem_d;
    initial forever #4 mclk = ~mclk;
    emb_bus_if dut_u (.mclk_in(mclk), .rstn_in(rstn), .reset_pin_in(rst_pin),
        .external_access_select_n_in(ea_n), .latch_strobe_off_bit_in(ao), .req_valid_in(valid),
        .req_kind_in(kind), .req_addr_in(addr), .req_wdata_in(wdata), .low_address_data_port_in(port_w),
        .req_ready_out(ready), .rsp_valid_out(rsp_v), .rsp_internal_out(rsp_int), .rsp_data_out(rsp_d),
        .low_address_data_port_out(p0_q), .low_address_data_port_oe_n_out(oe_n),
        .high_address_port_out(p2_q), .address_latch_strobe_out(ale), .program_fetch_strobe_n_out(pf_n),
        .read_strobe_n_out(rd_n), .write_strobe_n_out(wr_n));
    emb_ext_mem mem_u (.mclk_in(mclk), .port_in(port_w), .high_in(p2_q), .ale_in(ale),
        .program_fetch_strobe_n_in(pf_n), .read_strobe_n_in(rd_n), .write_strobe_n_in(wr_n),
        .drive_out(mem_d), .addr_out(mem_addr));
    // ========================================
    // Tasks
    task automatic end_of_test;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle
    task automatic wait_ready;
        for (int i = 0; i < 30 && ready !== 1'b1; i++) @(negedge mclk);
        `CHK(ready, 1'b1)
        idle(1);
    endtask : wait_ready
    task automatic access(input emb_acc_t k, input logic [15:0] a, input logic [7:0] d);
        logic prev;
        kind = k;
        addr = a;
        wdata = d;
        valid = 1;
        {n_pf, n_rd, n_wr, n_ale, n_oe} = '0;
        prev = ale;
        @(negedge mclk);
        for (int i = 0; i < 40 && ready !== 1'b1; i++) @(negedge mclk);
        idle(1);
        valid = 0;
        for (int i = 0; i < 40 && rsp_v !== 1'b1; i++) begin
            @(negedge mclk);
            n_pf += (pf_n === 1'b0);
            n_rd += (rd_n === 1'b0);
            n_wr += (wr_n === 1'b0);
            n_oe += (oe_n === 1'b0);
            n_ale += (prev === 1'b1 && ale === 1'b0);
            prev = ale;
            if (!pf_n || !rd_n || !wr_n) `CHK({ale, mem_addr}, {1'b0, a})
        end
        `CHK(rsp_v, 1'b1)
        got_int = rsp_int;
        got_d = rsp_d;
        wait_ready();
    endtask : access
    task automatic count_ale(input int exp_hi);
        int n = 0;
        repeat (20) begin
            @(negedge mclk);
            n += (ale === 1'b1);
        end
        `CHK(n > 0, exp_hi[0])
        idle(1);
    endtask : count_ale
    // ========================================
    // Scenarios
    task automatic t_ext_code;
        ea_n = 0;
        idle(4);
        access(EMB_ACC_CODE, 16'h0123, 8'h00);
        `CHK({got_int, got_d}, {1'b0, 8'h23 ^ 8'h01 ^ 8'h3C})
        `CHK({n_pf > 0, n_rd, n_ale > 0, n_oe > 0}, {1'b1, 32'd0, 1'b1, 1'b1})
    endtask : t_ext_code
    task automatic t_int_code;
        ea_n = 1;
        idle(4);
        access(EMB_ACC_CODE, 16'h1FFF, 8'h00);
        `CHK({got_int, got_d, n_pf, n_oe}, {1'b1, 8'h00, 32'd0, 32'd0})
        access(EMB_ACC_CODE, 16'h2000, 8'h00);
        `CHK({got_int, got_d, n_pf > 0}, {1'b0, 8'h20 ^ 8'h3C, 1'b1})
    endtask : t_int_code
    task automatic t_data;
        access(EMB_ACC_WRITE, 16'h1234, 8'hA7);
        `CHK({got_int, n_wr > 0, n_pf, n_rd}, {1'b0, 1'b1, 32'd0, 32'd0})
        access(EMB_ACC_READ, 16'h1234, 8'h00);
        `CHK({got_d, n_rd > 0, n_pf, n_wr}, {8'hA7, 1'b1, 32'd0, 32'd0})
        ea_n = 0;
        idle(4);
        access(EMB_ACC_CODE, 16'h1234, 8'h00);
        `CHK(got_d, 8'h34 ^ 8'h12 ^ 8'h3C)
    endtask : t_data
    task automatic t_ale_off;
        ea_n = 1;
        ao = 1;
        idle(4);
        count_ale(0);
        access(EMB_ACC_CODE, 16'h4000, 8'h00);
        `CHK(n_ale > 0, 1'b1)
        idle(3);
        count_ale(0);
        ao = 0;
        idle(4);
        count_ale(1);
    endtask : t_ale_off
    task automatic t_reset_pin;
        rst_pin = 1;
        for (int i = 0; i < 12; i++) begin
            @(negedge mclk);
            `CHK(ready, 1'b1)
        end
        idle(1);
        rst_pin = 0;
        idle(4);
        rst_pin = 1;
        idle(30);
        `CHK(ready, 1'b0)
        rst_pin = 0;
        wait_ready();
        access(EMB_ACC_READ, 16'h1234, 8'h00);
        `CHK(got_d, 8'hA7)
    endtask : t_reset_pin
    // ========================================
    // Main sequence and watchdog
    initial begin
        repeat (12) @(posedge mclk);
        #1 rstn = 1;
        wait_ready();
        t_ext_code();
        t_int_code();
        t_data();
        t_ale_off();
        t_reset_pin();
        end_of_test();
    end
    initial begin
        #(8 * 3000);
        error_cnt++;
        end_of_test();
    end
endmodule : emb_bus_if_bench
